/* File: src/calendar_clock_with_battery_ram.sv */
// calendar clock with battery-backed byte array, periodic interrupt and suspend support
`timescale 1ns/100ps
`include "cal_clock_regs.svh"

// Notes on behaviour
// - 128-byte array with calendar, time, alarm fields and a periodic interrupt.
// - ten locations hold time, calendar and alarms; update logic maintains the seven time and calendar bytes.
// - registers A to D control the clock; other 114 bytes are free storage.
// - each divider one-second tick advances the calendar and time counts unless the set bit is held.
// - updates apply daylight-saving shifts and leap-year days.
// - fields are kept in binary or BCD as the format bit selects.
// - total power loss without battery clears the contents-valid flag in D.
// - host reads register D after power-up; that read sets the flag again.
// - time base keeps running whatever the suspend or power state.
// - divider chain turns the 32.768 KHz base into a 1 Hz tick.
// - divider stages 1 to 13 are offered to the periodic rate selector.
// - register A picks a periodic interrupt pulse from 122 us to 500 ms.
// - periodic pulses appear only while the periodic enable bit is set.
// - each update compares the new time against the alarm bytes.
// - update-in-progress and set bits keep host accesses clear of updates.
// - host moves byte data D0-D7 through decoded select and strobes.
// - fast clock output of 14.318 MHz drops to 32.768 KHz in suspend.
// - refresh output pulses low once every 15.26 us.
// - suspend latch holds both serial selects and parallel select low.
module calendar_clock_with_battery_ram
    import cal_clock_pkg::*;
#(
    parameter int unsigned CLK_HZ = 200000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic powerLossNoBattery,
    input wire logic serialASelectIn,
    input wire logic serialBSelectIn,
    input wire logic parallelSelectIn,
    output logic clockInterruptOut,
    output logic fastClockOut,
    output logic dramRefreshPulse_n,
    output logic serialASelect,
    output logic serialBSelect,
    output logic parallelPortSelect,
    output logic suspendActive
);

    localparam logic [31:0] CLK_MOD = 32'(CLK_HZ);
    localparam logic [31:0] TB_STEP = 32'(2 * `TIMEBASE_HZ);
    localparam logic [31:0] FC_STEP = 32'(2 * `FASTCLK_HZ);
    localparam logic [15:0] REFRESH_CYC =
        16'((64'(`REFRESH_PERIOD_CENTI_US) * 64'(CLK_HZ)) / 64'(`CENTI_US_PER_S));

    function automatic logic [7:0] toBin(input logic [7:0] v, input logic bin);
        toBin = bin ? v : ({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]};
    endfunction
    function automatic logic [7:0] fromBin(input logic [7:0] v, input logic bin);
        fromBin = bin ? v : {4'(v / 8'h0A), 4'(v % 8'h0A)};
    endfunction
    function automatic logic [7:0] hourToBin(input logic [7:0] v, input logic bin, input logic h24);
        logic [7:0] h;
        h = toBin({1'b0, v[6:0]}, bin);
        if (!h24) begin
            if (h == `HOURS_HALF) begin
                h = 8'h00;
            end
            if (v[7]) begin
                h = h + `HOURS_HALF;
            end
        end
        hourToBin = h;
    endfunction
    function automatic logic [7:0] hourFromBin(input logic [7:0] h, input logic bin, input logic h24);
        logic pm;
        logic [7:0] t;
        pm = (h >= `HOURS_HALF);
        t = pm ? h - `HOURS_HALF : h;
        if (t == 8'h00) begin
            t = `HOURS_HALF;
        end
        t = fromBin(t, bin);
        hourFromBin = h24 ? fromBin(h, bin) : {pm, t[6:0]};
    endfunction
    function automatic logic [7:0] monthDays(input logic [7:0] mon, input logic [7:0] yr);
        case (mon)
            8'h02: monthDays = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: monthDays = 8'h1E;
            default: monthDays = 8'h1F;
        endcase
    endfunction
    function automatic logic alarmMatch(input logic [7:0] alm, input logic [7:0] cur);
        alarmMatch = (alm[7:6] == `ALARM_ANY) || (alm == cur);
    endfunction
    logic [7:0] ram_r [0:`RAM_BYTES-1];
    logic [7:0] ram_nxt [0:`RAM_BYTES-1];
    logic [31:0] tbAcc_r, tbAcc_nxt, fcAcc_r, fcAcc_nxt;
    logic tbPhase_r, tbPhase_nxt, fastClk_r, fastClk_nxt;
    logic [`DIV_STAGES-1:0] div_r, div_nxt;
    logic [15:0] refCnt_r, refCnt_nxt;
    logic refresh_r, refresh_nxt;
    upd_state_type state_r, state_nxt;
    time_type wk_r, wk_nxt, calcT, fmtT;
    logic dstBack_r, dstBack_nxt;
    event_type flags_r, flags_nxt, evt;
    logic valid_r, valid_nxt, irqPulse_r, irqPulse_nxt, susp_r, susp_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic halfTick, tick32k, divRun, oneHz, periodicEvt, calcWrite, alarmHit, uip;
    logic [31:0] tbSum, fcSum;
    logic [`DIV_STAGES-1:0] stageWrap;
    logic [3:0] rs, tapIdx;
    logic access, hostWr, hostRd, inRam, isSusp, readC, readD;
    logic [6:0] idx;
    logic [7:0] regA, regB;
    assign regA = ram_r[`IDX_CTRL_A];
    assign regB = ram_r[`IDX_CTRL_B];
    // byte transfers on the low data lanes
    assign access = psel & penable;
    assign hostWr = access & pwrite;
    assign hostRd = access & ~pwrite;
    assign idx = paddr[8:2];
    assign inRam = ~paddr[9];
    assign isSusp = (paddr == `ADDR_SUSPEND);
    assign readC = hostRd & inRam & (idx == `IDX_STAT_C);
    assign readD = hostRd & inRam & (idx == `IDX_STAT_D);
    assign pready = 1'b1;
    assign pslverr = access & ~inRam & ~isSusp;

    always_comb begin
        prdata = 32'h0000_0000;
        if (!inRam) begin
            if (isSusp) begin
                prdata = {31'h0000_0000, susp_r};
            end
        end else if (idx == `IDX_CTRL_A) begin
            prdata = {24'h00_0000, uip, regA[6:0]};
        end else if (idx == `IDX_STAT_C) begin
            prdata = {24'h00_0000, |(flags_r & {regB[`B_PERIODIC_IRQ_ENABLE],
                      regB[`B_ALARM_IRQ_ENABLE], regB[`B_UPDATE_IRQ_ENABLE]}), flags_r, 4'h0};
        end else if (idx == `IDX_STAT_D) begin
            prdata = {24'h00_0000, valid_r, 7'h00};
        end else begin
            prdata = {24'h00_0000, ram_r[idx]};
        end
    end

    // time base, fast clock, divider chain and refresh
    assign tbSum = tbAcc_r + TB_STEP;
    assign halfTick = (tbSum >= CLK_MOD);
    assign tick32k = halfTick & tbPhase_r;
    assign fcSum = fcAcc_r + FC_STEP;
    assign divRun = (regA[`A_DV] == `DV_RUN);

    // each stage reports its own rollover
    genvar g;
    generate
        for (g = 0; g < `DIV_STAGES; g++) begin : g_stage
            assign stageWrap[g] = tick32k & divRun & (&div_r[g:0]);
        end
    endgenerate

    // last stage rollover is the 1 Hz tick
    assign oneHz = stageWrap[`DIV_STAGES-1];
    // rate select: slow codes sit further down the chain
    assign rs = regA[`A_RS];
    assign tapIdx = (rs <= `RS_SLOW_MAX) ? rs + `RS_SLOW_BASE : rs - `RS_FAST_OFFSET;
    assign periodicEvt = (rs != 4'h0) & stageWrap[tapIdx];
    // warning raised one time-base period ahead of the update
    assign uip = (divRun & ~regB[`B_SET] & (&div_r)) | (state_r != UPD_IDLE);

    always_comb begin
        // nothing here but the fast clock half periods depends on suspend or power state
        tbAcc_nxt = halfTick ? tbSum - CLK_MOD : tbSum;
        tbPhase_nxt = tbPhase_r ^ halfTick;
        div_nxt = div_r;
        if (!divRun) begin
            div_nxt = '0;
        end else if (tick32k) begin
            div_nxt = div_r + 1'b1;
        end
        fcAcc_nxt = (fcSum >= CLK_MOD) ? fcSum - CLK_MOD : fcSum;
        fastClk_nxt = fastClk_r;
        // half periods follow the time base while suspended
        if (susp_r ? halfTick : (fcSum >= CLK_MOD)) begin
            fastClk_nxt = ~fastClk_r;
        end
        // one low cycle per refresh period
        refresh_nxt = (refCnt_r == REFRESH_CYC - 16'h0001);
        refCnt_nxt = refresh_nxt ? 16'h0000 : refCnt_r + 16'h0001;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tbAcc_r <= 32'h0000_0000;
            tbPhase_r <= 1'b0;
            fcAcc_r <= 32'h0000_0000;
            fastClk_r <= 1'b0;
            div_r <= '0;
            refCnt_r <= 16'h0000;
            refresh_r <= 1'b0;
        end else begin
            tbAcc_r <= tbAcc_nxt;
            tbPhase_r <= tbPhase_nxt;
            fcAcc_r <= fcAcc_nxt;
            fastClk_r <= fastClk_nxt;
            div_r <= div_nxt;
            refCnt_r <= refCnt_nxt;
            refresh_r <= refresh_nxt;
        end
    end

    // update sequencer: capture in binary, then carry and write back in one pass
    always_comb begin
        logic bin;
        logic h24;
        bin = regB[`B_BINARY];
        h24 = regB[`B_24H];
        state_nxt = state_r;
        wk_nxt = wk_r;
        dstBack_nxt = dstBack_r;
        calcWrite = 1'b0;
        calcT = wk_r;
        case (state_r)
            UPD_IDLE: begin
                // tick starts an update unless the host holds the set bit
                if (oneHz && !regB[`B_SET]) begin
                    wk_nxt.sec = toBin(ram_r[`IDX_SEC], bin);
                    wk_nxt.min = toBin(ram_r[`IDX_MIN], bin);
                    wk_nxt.hour = hourToBin(ram_r[`IDX_HOUR], bin, h24);
                    wk_nxt.dow = toBin(ram_r[`IDX_DOW], bin);
                    wk_nxt.dom = toBin(ram_r[`IDX_DOM], bin);
                    wk_nxt.mon = toBin(ram_r[`IDX_MON], bin);
                    wk_nxt.yr = toBin(ram_r[`IDX_YEAR], bin);
                    state_nxt = UPD_CALC;
                end
            end
            UPD_CALC: begin
                // all carries resolve in this single cycle
                calcWrite = 1'b1;
                state_nxt = UPD_IDLE;
                calcT.sec = wk_r.sec + 8'h01;
                if (calcT.sec >= `SEC_WRAP) begin
                    calcT.sec = 8'h00;
                    calcT.min = wk_r.min + 8'h01;
                    if (calcT.min >= `MIN_WRAP) begin
                        calcT.min = 8'h00;
                        calcT.hour = wk_r.hour + 8'h01;
                        // daylight-saving shift on the last Sunday of spring and fall months
                        if (regB[`B_DST_ENABLE] && wk_r.dow == `DST_SUNDAY) begin
                            if (wk_r.mon == `DST_SPRING_MON && wk_r.dom >= `DST_SPRING_DOM &&
                                calcT.hour == `DST_SPRING_HOUR) begin
                                calcT.hour = `DST_SPRING_HOUR + 8'h01;
                            end
                            if (wk_r.mon == `DST_FALL_MON && wk_r.dom >= `DST_FALL_DOM &&
                                wk_r.hour == `DST_FALL_HOUR && !dstBack_r) begin
                                calcT.hour = `DST_FALL_HOUR;
                                dstBack_nxt = 1'b1;
                            end
                        end
                        if (calcT.hour >= `HOUR_WRAP) begin
                            calcT.hour = 8'h00;
                            dstBack_nxt = 1'b0;
                            calcT.dow = (wk_r.dow >= `DOW_MAX) ? 8'h01 : wk_r.dow + 8'h01;
                            // leap February through the month length
                            if (wk_r.dom >= monthDays(wk_r.mon, wk_r.yr)) begin
                                calcT.dom = 8'h01;
                                calcT.mon = (wk_r.mon >= `MON_MAX) ? 8'h01 : wk_r.mon + 8'h01;
                                if (wk_r.mon >= `MON_MAX) begin
                                    calcT.yr = (wk_r.yr + 8'h01 >= `YEAR_WRAP) ? 8'h00 : wk_r.yr + 8'h01;
                                end
                            end else begin
                                calcT.dom = wk_r.dom + 8'h01;
                            end
                        end
                    end
                end
            end
            default: state_nxt = UPD_IDLE;
        endcase
        fmtT.sec = fromBin(calcT.sec, bin);
        fmtT.min = fromBin(calcT.min, bin);
        fmtT.hour = hourFromBin(calcT.hour, bin, h24);
        fmtT.dow = fromBin(calcT.dow, bin);
        fmtT.dom = fromBin(calcT.dom, bin);
        fmtT.mon = fromBin(calcT.mon, bin);
        fmtT.yr = fromBin(calcT.yr, bin);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= UPD_IDLE;
            wk_r <= '0;
            dstBack_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wk_r <= wk_nxt;
            dstBack_r <= dstBack_nxt;
        end
    end

    // alarm compared against the freshly written time
    assign alarmHit = calcWrite & alarmMatch(ram_r[`IDX_SEC_ALM], fmtT.sec) &
                      alarmMatch(ram_r[`IDX_MIN_ALM], fmtT.min) &
                      alarmMatch(ram_r[`IDX_HOUR_ALM], fmtT.hour);

    // byte array; status C and D live in flags_r and valid_r, not here
    always_comb begin
        ram_nxt = ram_r;
        // update logic owns the seven time and calendar bytes
        if (calcWrite) begin
            ram_nxt[`IDX_SEC] = fmtT.sec;
            ram_nxt[`IDX_MIN] = fmtT.min;
            ram_nxt[`IDX_HOUR] = fmtT.hour;
            ram_nxt[`IDX_DOW] = fmtT.dow;
            ram_nxt[`IDX_DOM] = fmtT.dom;
            ram_nxt[`IDX_MON] = fmtT.mon;
            ram_nxt[`IDX_YEAR] = fmtT.yr;
        end
        // host writes land after the update so a late host write is kept
        if (hostWr && inRam && idx != `IDX_STAT_C && idx != `IDX_STAT_D) begin
            ram_nxt[idx] = pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // byte array cleared at reset, then A, B, day of month and month load their reset values
            for (int i = 0; i < `RAM_BYTES; i++) begin
                ram_r[i] <= 8'h00;
            end
            ram_r[`IDX_CTRL_A] <= `A_RESET;
            ram_r[`IDX_CTRL_B] <= `B_RESET;
            ram_r[`IDX_DOM] <= `DATE_RESET;
            ram_r[`IDX_MON] <= `DATE_RESET;
        end else begin
            ram_r <= ram_nxt;
        end
    end

    // event flags, contents-valid, interrupt pulse and suspend latch
    always_comb begin
        evt.periodic = periodicEvt;
        evt.alarm = alarmHit;
        evt.update = calcWrite;
        // reading C clears, but an event in the same cycle survives
        flags_nxt = evt | (flags_r & {3{~readC}});
        // periodic pulse gated by its enable
        irqPulse_nxt = (periodicEvt & regB[`B_PERIODIC_IRQ_ENABLE]) |
                       (alarmHit & regB[`B_ALARM_IRQ_ENABLE]) |
                       (calcWrite & regB[`B_UPDATE_IRQ_ENABLE]);
        valid_nxt = valid_r;
        if (readD) begin
            valid_nxt = 1'b1;
        end
        // power loss clears it and beats a same-cycle read
        if (powerLossNoBattery) begin
            valid_nxt = 1'b0;
        end
        susp_nxt = (hostWr && isSusp) ? pwdata[`SUSP_BIT] : susp_r;
        // selects forced low while the suspend latch is set
        sel_nxt = susp_r ? 3'h0 : {serialASelectIn, serialBSelectIn, parallelSelectIn};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= '0;
            irqPulse_r <= 1'b0;
            valid_r <= 1'b0;
            susp_r <= 1'b0;
            sel_r <= 3'h0;
        end else begin
            flags_r <= flags_nxt;
            irqPulse_r <= irqPulse_nxt;
            valid_r <= valid_nxt;
            susp_r <= susp_nxt;
            sel_r <= sel_nxt;
        end
    end

    assign clockInterruptOut = irqPulse_r;
    assign fastClockOut = fastClk_r;
    assign dramRefreshPulse_n = ~refresh_r;
    assign serialASelect = sel_r[2];
    assign serialBSelect = sel_r[1];
    assign parallelPortSelect = sel_r[0];
    assign suspendActive = susp_r;

endmodule

/* File: src/cal_clock_regs.svh */
// register indices, field positions, reset values and timing figures of the calendar clock
`ifndef CAL_CLOCK_REGS_SVH
`define CAL_CLOCK_REGS_SVH

`define RAM_BYTES 128
`define IDX_SEC 7'h00
`define IDX_SEC_ALM 7'h01
`define IDX_MIN 7'h02
`define IDX_MIN_ALM 7'h03
`define IDX_HOUR 7'h04
`define IDX_HOUR_ALM 7'h05
`define IDX_DOW 7'h06
`define IDX_DOM 7'h07
`define IDX_MON 7'h08
`define IDX_YEAR 7'h09
`define IDX_CTRL_A 7'h0A
`define IDX_CTRL_B 7'h0B
`define IDX_STAT_C 7'h0C
`define IDX_STAT_D 7'h0D
`define ADDR_SUSPEND 10'h200

`define A_UIP 7
`define A_DV 6:4
`define A_RS 3:0
`define DV_RUN 3'h2
`define B_SET 7
`define B_PERIODIC_IRQ_ENABLE 6
`define B_ALARM_IRQ_ENABLE 5
`define B_UPDATE_IRQ_ENABLE 4
`define B_BINARY 2
`define B_24H 1
`define B_DST_ENABLE 0
`define D_VALID 7
`define SUSP_BIT 0

`define A_RESET 8'h26
`define B_RESET 8'h02
`define DATE_RESET 8'h01
`define ALARM_ANY 2'h3

`define SEC_WRAP 8'h3C
`define MIN_WRAP 8'h3C
`define HOUR_WRAP 8'h18
`define HOURS_HALF 8'h0C
`define DOW_MAX 8'h07
`define MON_MAX 8'h0C
`define YEAR_WRAP 8'h64
`define DST_SUNDAY 8'h01
`define DST_SPRING_MON 8'h04
`define DST_SPRING_DOM 8'h18
`define DST_SPRING_HOUR 8'h02
`define DST_FALL_MON 8'h0A
`define DST_FALL_DOM 8'h19
`define DST_FALL_HOUR 8'h01

`define DIV_STAGES 15
`define RS_SLOW_MAX 4'h2
`define RS_SLOW_BASE 4'h5
`define RS_FAST_OFFSET 4'h2
`define TIMEBASE_HZ 32768
`define FASTCLK_HZ 14318000
`define REFRESH_PERIOD_CENTI_US 1526
`define CENTI_US_PER_S 100000000

`endif

/* File: src/cal_clock_pkg.sv */
// shared types for the calendar clock
package cal_clock_pkg;
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] dow;
        logic [7:0] dom;
        logic [7:0] mon;
        logic [7:0] yr;
    } time_type;

    typedef struct packed {
        logic periodic;
        logic alarm;
        logic update;
    } event_type;

    typedef enum {UPD_IDLE, UPD_CALC} upd_state_type;
endpackage

/* File: sim/cal_clock_chk.sv */
// port assertions for the calendar clock
`timescale 1ns/100ps
module cal_clock_chk #(
    parameter int unsigned CLK_HZ = 200000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic powerLossNoBattery,
    input wire logic serialASelectIn,
    input wire logic clockInterruptOut,
    input wire logic serialASelect,
    input wire logic serialBSelect,
    input wire logic parallelPortSelect,
    input wire logic suspendActive
);
    logic [2:0] enB_r, enB_nxt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence access_s; psel && penable; endsequence
    sequence readD_s; psel && penable && !pwrite && paddr == 10'h034; endsequence
    sequence suspWr_s; psel && penable && pwrite && paddr == 10'h200; endsequence
    // shadow of the three interrupt enables, so quiet periods can be judged
    always_comb begin
        enB_nxt = enB_r;
        if (psel && penable && pwrite && paddr == 10'h02C) begin
            enB_nxt = pwdata[6:4];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enB_r <= 3'h0;
        end else begin
            enB_r <= enB_nxt;
        end
    end
    ready_now_a: assert property (access_s |-> pready)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (psel && penable && paddr >= 10'h204 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && penable && paddr < 10'h200 |-> !pslverr)
        else $error("mapped access refused");
    irq_once_a: assert property ($rose(clockInterruptOut) |=> !clockInterruptOut)
        else $error("interrupt pulse too long");
    irq_quiet_a: assert property ((enB_r == 3'h0)[*3] |-> !clockInterruptOut)
        else $error("interrupt while disabled");
    susp_set_a: assert property (suspWr_s |=> suspendActive == $past(pwdata[0]))
        else $error("suspend latch not written");
    susp_hold_a: assert property (suspendActive && $past(suspendActive)
        |-> !serialASelect && !serialBSelect && !parallelPortSelect)
        else $error("select high in suspend");
    sel_copy_a: assert property (!suspendActive && !$past(suspendActive)
        |-> serialASelect == $past(serialASelectIn))
        else $error("select not passed through");
    valid_set_a: assert property (readD_s ##3 readD_s |-> prdata[7] || $past(powerLossNoBattery)
        || $past(powerLossNoBattery, 2) || $past(powerLossNoBattery, 3))
        else $error("valid flag not set by read");
    loss_clear_a: assert property (powerLossNoBattery ##1 readD_s |-> !prdata[7])
        else $error("valid flag survived power loss");
endmodule

bind calendar_clock_with_battery_ram cal_clock_chk #(.CLK_HZ(CLK_HZ)) u_chk (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .powerLossNoBattery, .serialASelectIn, .clockInterruptOut, .serialASelect,
    .serialBSelect, .parallelPortSelect, .suspendActive
);

/* File: sim/apb_host_model.sv */
// host processor model driving the register bus
`timescale 1ns/100ps
module apb_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [9:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                        output logic [31:0] rdat, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        err = pslverr;
        // one idle cycle keeps the release apart from the next setup
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
endmodule

/* File: sim/test_calendar_clock_with_battery_ram.sv */
// self-checking bench for the calendar clock
`timescale 1ns/100ps
module test_calendar_clock_with_battery_ram;
    // one time-base tick every two cycles keeps a whole second short
    localparam int unsigned SIM_HZ = 65536;
    localparam int CYC_PER_TICK = SIM_HZ / 32768;
    localparam int REF_CYC = 1526 * SIM_HZ / 100000000;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic powerLossNoBattery, serialASelectIn, serialBSelectIn, parallelSelectIn;
    logic clockInterruptOut, fastClockOut, dramRefreshPulse_n, suspendActive;
    logic serialASelect, serialBSelect, parallelPortSelect;
    int errCount = 0;
    int numChecks = 0;
    int cycleCount = 0;
    logic [31:0] rndState = 32'h29;
    logic [7:0] mem [128];
    logic [7:0] setVal [10] = '{8'h59, 8'hC0, 8'h59, 8'hC0, 8'h23, 8'hC0, 8'h07, 8'h28, 8'h02, 8'h04};

    calendar_clock_with_battery_ram #(.CLK_HZ(SIM_HZ)) u_dut (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .powerLossNoBattery, .serialASelectIn, .serialBSelectIn, .parallelSelectIn,
        .clockInterruptOut, .fastClockOut, .dramRefreshPulse_n, .serialASelect,
        .serialBSelect, .parallelPortSelect, .suspendActive
    );
    apb_host_model u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    function automatic logic [31:0] nextRnd();
        rndState ^= rndState << 13;
        rndState ^= rndState >> 17;
        rndState ^= rndState << 5;
        return rndState;
    endfunction
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            errCount++;
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b0, a, 32'h0, r, e);
        check("read data", exp, r);
        check("error flag", {31'h0, expErr}, {31'h0, e});
    endtask
    task automatic pulseGap(output int g);
        g = 0;
        while (clockInterruptOut !== 1'b1) begin
            @(posedge clk);
        end
        do begin
            @(posedge clk);
            g++;
        end while (clockInterruptOut !== 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycleCount++;
        if (cycleCount == 100000) begin
            errCount++;
            giveVerdict();
        end
    end
    initial begin
        int g, r;
        logic f;
        rst_n = 1'b0;
        powerLossNoBattery = 1'b0;
        serialASelectIn = 1'b0;
        serialBSelectIn = 1'b0;
        parallelSelectIn = 1'b0;
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'h00;
        end
        mem[7] = 8'h01;
        mem[8] = 8'h01;
        mem[10] = 8'h26;
        mem[11] = 8'h02;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            if (i != 12) begin
                rd(10'(i * 4), {24'h0, mem[i]}, 1'b0);
            end
        end
        for (int i = 14; i < 128; i++) begin
            mem[i] = 8'(nextRnd());
            {serialASelectIn, serialBSelectIn, parallelSelectIn} <= rndState[10:8];
            wr(10'(i * 4), mem[i]);
        end
        for (int i = 14; i < 128; i++) begin
            rd(10'(i * 4), {24'h0, mem[i]}, 1'b0);
        end
        wr(10'h034, 8'hFF);
        rd(10'h034, 32'h80, 1'b0);
        rd(10'h204, 32'h0, 1'b1);
        powerLossNoBattery <= 1'b1;
        rd(10'h034, 32'h0, 1'b0);
        powerLossNoBattery <= 1'b0;
        rd(10'h034, 32'h0, 1'b0);
        rd(10'h034, 32'h80, 1'b0);
        wr(10'h028, 8'h23);
        g = 0;
        r = 0;
        repeat (100) begin
            @(posedge clk);
            g += (clockInterruptOut === 1'b1);
            r += (dramRefreshPulse_n === 1'b0);
        end
        check("pulses", 32'h0, 32'(g));
        check("refresh lows", 32'(100 / REF_CYC), 32'(r));
        wr(10'h02C, 8'h42);
        for (int n = 1; n < 10; n++) begin
            wr(10'h028, 8'h20 | 8'(n));
            pulseGap(g);
            pulseGap(g);
            check("gap", 32'((n < 3 ? (64 << n) : (1 << (n - 1))) * CYC_PER_TICK), 32'(g));
        end
        {serialASelectIn, serialBSelectIn, parallelSelectIn} <= 3'h7;
        wr(10'h200, 8'h01);
        @(posedge clk);
        check("selects", 32'h0, {29'h0, serialASelect, serialBSelect, parallelPortSelect});
        f = fastClockOut;
        g = 0;
        repeat (8) begin
            @(posedge clk);
            g += (fastClockOut !== f);
            f = fastClockOut;
        end
        check("fast clock edges", 32'(16 * 32768 / SIM_HZ), 32'(g));
        rd(10'h200, 32'h1, 1'b0);
        wr(10'h200, 8'h00);
        @(posedge clk);
        check("selects", 32'h7, {29'h0, serialASelect, serialBSelect, parallelPortSelect});
        wr(10'h028, 8'h20);
        wr(10'h02C, 8'h82);
        for (int i = 0; i < 10; i++) begin
            mem[i] = setVal[i];
            wr(10'(i * 4), mem[i]);
        end
        wr(10'h02C, 8'h32);
        while (clockInterruptOut !== 1'b1) begin
            @(posedge clk);
        end
        // leap year: 28 Feb 23:59:59 Saturday rolls to 29 Feb Sunday
        mem[0] = 8'h00;
        mem[2] = 8'h00;
        mem[4] = 8'h00;
        mem[6] = 8'h01;
        mem[7] = 8'h29;
        for (int i = 0; i < 10; i++) begin
            rd(10'(i * 4), {24'h0, mem[i]}, 1'b0);
        end
        rd(10'h030, 32'hF0, 1'b0);
        rd(10'h030, 32'h0, 1'b0);
        giveVerdict();
    end
endmodule
